// ==== scs_clock_select.sv ====
// System clock source selection with glitch-free switching and status.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
module scs_clock_select
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic config_loaded,
  input wire logic default_source_config_bit,
  input wire logic two_speed_enable,
  input wire logic primary_osc,
  input wire logic secondary_osc,
  input wire logic internal_osc,
  input wire logic internal_stable,
  output logic [1:0] active_source,
  output logic clock_gate,
  output logic cpu_clock_enable,
  output logic periph_clock_enable,
  output logic switching
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  scs_osc_s osc_raw;
  scs_osc_s osc;
  logic [3:0] pin_raw;
  logic [3:0] pin_sync;
  logic two_speed_s;
  logic cfg_loaded_s;
  logic default_src_s;
  logic int_stable_s;

  assign osc_raw = '{primary: primary_osc, secondary: secondary_osc,
                     internal: internal_osc};
  // The strap comes from a pin too, so it is synchronised with the rest.
  assign pin_raw = {two_speed_enable, config_loaded,
                    default_source_config_bit, internal_stable};

  scs_sync #(.WIDTH(3)) u_osc_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .din(osc_raw),
    .dout(osc)
  );

  scs_sync #(.WIDTH(4)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .din(pin_raw),
    .dout(pin_sync)
  );

  assign two_speed_s = pin_sync[3];
  assign cfg_loaded_s = pin_sync[2];
  assign default_src_s = pin_sync[1];
  assign int_stable_s = pin_sync[0];

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  scs_bus_s bus;
  logic [1:0] clock_select_field;
  logic idle_enable_bit;
  logic timer_osc_enable_bit;
  logic oscillator_status_bit;
  logic timer_osc_running_bit;
  logic two_speed_latched;
  logic cfg_done;
  scs_pwr_e pwr_state;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Select field; secondary choice needs the timer oscillator enabled.
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_select_field <= SELECT_RESET;
    end else if (ce) begin
      if (bus.wr && bus.addr == OSC_CONTROL_ADDR) begin
        if (bus.wdata[SELECT_LSB +: 2] != SEL_SECONDARY ||
            timer_osc_enable_bit) begin
          clock_select_field <= bus.wdata[SELECT_LSB +: 2];
        end
      end
    end
  end

  // Idle enable bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_enable_bit <= IDLE_ENABLE_RESET;
    end else if (ce) begin
      if (bus.wr && bus.addr == OSC_CONTROL_ADDR) begin
        idle_enable_bit <= bus.wdata[IDLE_ENABLE_POS];
      end
    end
  end

  // Timer oscillator enable in the timer control register.
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_osc_enable_bit <= TIMER_OSC_ENABLE_RESET;
    end else if (ce) begin
      if (bus.wr && bus.addr == TIMER_CONTROL_ADDR) begin
        timer_osc_enable_bit <= bus.wdata[TIMER_OSC_ENABLE_POS];
      end
    end
  end

  // Synchronised two-speed strap is followed until configuration is done.
  always_ff @(posedge clk) begin
    if (rst) begin
      two_speed_latched <= 1'b0;
    end else if (ce && !cfg_done) begin
      two_speed_latched <= two_speed_s;
    end
  end

  // ----------------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------------
  scs_src_e wanted_src;
  scs_src_e cur_src;
  scs_src_e new_src;

  // Maps the select code and default-source bit onto a physical source.
  always_comb begin
    wanted_src = SCS_SRC_INTERNAL;
    if (!cfg_done) begin
      wanted_src = SCS_SRC_INTERNAL;
    end else begin
      case (clock_select_field)
        SEL_INTERNAL: wanted_src = SCS_SRC_INTERNAL;
        SEL_PRIMARY: wanted_src = SCS_SRC_PRIMARY;
        SEL_SECONDARY: wanted_src = SCS_SRC_SECONDARY;
        default: begin
          wanted_src = default_src_s ? SCS_SRC_PRIMARY :
                       SCS_SRC_INTERNAL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Switch sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCS_SW_RUN,
    SCS_SW_OLD,
    SCS_SW_NEW
  } scs_sw_e;

  scs_sw_e sw_state;
  logic cnt_clear;
  logic [2:0] old_count;
  logic [2:0] new_count;
  logic old_level;
  logic new_level;

  // Picks the level of a given source.
  function automatic logic src_level(scs_src_e s, scs_osc_s o);
    case (s)
      SCS_SRC_PRIMARY: src_level = o.primary;
      SCS_SRC_SECONDARY: src_level = o.secondary;
      default: src_level = o.internal;
    endcase
  endfunction

  assign old_level = src_level(cur_src, osc);
  assign new_level = src_level(new_src, osc);
  assign cnt_clear = (sw_state == SCS_SW_RUN);

  scs_edge_count #(.WIDTH(3)) u_old_cnt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(cnt_clear),
    .level(old_level),
    .count(old_count)
  );

  scs_edge_count #(.WIDTH(3)) u_new_cnt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(cnt_clear || sw_state == SCS_SW_OLD),
    .level(new_level),
    .count(new_count)
  );

  // Waits out two cycles of the old source with the gate off, then three of the new.
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_state <= SCS_SW_RUN;
      cur_src <= SCS_SRC_INTERNAL;
      new_src <= SCS_SRC_INTERNAL;
    end else if (ce) begin
      case (sw_state)
        SCS_SW_RUN: begin
          if (wanted_src != cur_src) begin
            new_src <= wanted_src;
            sw_state <= SCS_SW_OLD;
          end
        end
        SCS_SW_OLD: begin
          if (old_count >= 3'(OLD_SRC_CYCLES)) begin
            sw_state <= SCS_SW_NEW;
          end
        end
        SCS_SW_NEW: begin
          if (new_count >= 3'(NEW_SRC_CYCLES) &&
              (new_src != SCS_SRC_INTERNAL || int_stable_s)) begin
            cur_src <= new_src;
            sw_state <= SCS_SW_RUN;
          end
        end
        default: sw_state <= SCS_SW_RUN;
      endcase
    end
  end

  // Configuration is done once the synchronised load flag is seen.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_done <= 1'b0;
    end else if (ce && cfg_loaded_s) begin
      cfg_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Power state and status
  // ----------------------------------------------------------------------

  // Sleep command chooses idle or sleep; a write to the power state register wakes to run.
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_state <= SCS_PWR_RUN;
    end else if (ce) begin
      if (bus.wr && bus.addr == SLEEP_CMD_ADDR) begin
        pwr_state <= idle_enable_bit ? SCS_PWR_IDLE :
                     SCS_PWR_SLEEP;
      end else if (bus.wr && bus.addr == POWER_STATE_ADDR) begin
        pwr_state <= SCS_PWR_RUN;
      end
    end
  end

  // Status bits track the source now in use, mutually exclusive.
  always_ff @(posedge clk) begin
    if (rst) begin
      oscillator_status_bit <= 1'b1;
      timer_osc_running_bit <= 1'b0;
    end else if (ce) begin
      if (!cfg_done) begin
        oscillator_status_bit <= !two_speed_latched;
        timer_osc_running_bit <= 1'b0;
      end else if (sw_state == SCS_SW_RUN) begin
        oscillator_status_bit <= (clock_select_field == SEL_DEFAULT) &&
                                 (wanted_src == cur_src);
        timer_osc_running_bit <= (cur_src == SCS_SRC_SECONDARY) &&
                                 (clock_select_field != SEL_DEFAULT);
      end else begin
        oscillator_status_bit <= 1'b0;
        timer_osc_running_bit <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Clock gate is low through the whole switch so no runt pulse escapes.
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_gate <= 1'b0;
      switching <= 1'b0;
      active_source <= 2'h0;
      cpu_clock_enable <= 1'b0;
      periph_clock_enable <= 1'b0;
    end else if (ce) begin
      clock_gate <= (sw_state == SCS_SW_RUN) &&
                    (pwr_state != SCS_PWR_SLEEP);
      switching <= (sw_state != SCS_SW_RUN);
      active_source <= cur_src;
      cpu_clock_enable <= (sw_state == SCS_SW_RUN) &&
                          (pwr_state == SCS_PWR_RUN);
      periph_clock_enable <= (sw_state == SCS_SW_RUN) &&
                             (pwr_state != SCS_PWR_SLEEP);
    end
  end

  // Read data, one cycle after the strobe; reserved bits read zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (bus.rd) begin
        case (bus.addr)
          OSC_CONTROL_ADDR: begin
            rdata[IDLE_ENABLE_POS] <= idle_enable_bit;
            rdata[OSC_STATUS_POS] <= oscillator_status_bit;
            rdata[SELECT_LSB +: 2] <= clock_select_field;
          end
          TIMER_CONTROL_ADDR: begin
            rdata[TIMER_RUNNING_POS] <= timer_osc_running_bit;
            rdata[TIMER_OSC_ENABLE_POS] <= timer_osc_enable_bit;
          end
          POWER_STATE_ADDR: rdata[1:0] <= pwr_state;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ==== scs_pkg.sv ====
// Package with register layout, source codes and timing counts for the clock select block.
package scs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] OSC_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] TIMER_CONTROL_ADDR = 4'h1;
  localparam logic [3:0] SLEEP_CMD_ADDR = 4'h2;
  localparam logic [3:0] POWER_STATE_ADDR = 4'h3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int IDLE_ENABLE_POS = 7;
  localparam int OSC_STATUS_POS = 3;
  localparam int SELECT_LSB = 0;
  localparam int TIMER_RUNNING_POS = 6;
  localparam int TIMER_OSC_ENABLE_POS = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] SELECT_RESET = 2'h0;
  localparam logic IDLE_ENABLE_RESET = 1'b0;
  localparam logic TIMER_OSC_ENABLE_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // Select codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_PRIMARY = 2'h2;
  localparam logic [1:0] SEL_INTERNAL = 2'h3;

  // ----------------------------------------------------------------------
  // Switch timing, in cycles of the old and the new source, and synchroniser depth in stages
  // ----------------------------------------------------------------------
  localparam int OLD_SRC_CYCLES = 2;
  localparam int NEW_SRC_CYCLES = 3;
  localparam int SYNC_STAGES = 2;

  // Physical clock sources.
  typedef enum logic [1:0] {
    SCS_SRC_INTERNAL,
    SCS_SRC_PRIMARY,
    SCS_SRC_SECONDARY
  } scs_src_e;

  // Power state as seen by software.
  typedef enum logic [1:0] {
    SCS_PWR_RUN,
    SCS_PWR_IDLE,
    SCS_PWR_SLEEP
  } scs_pwr_e;

  // Register bus request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scs_bus_s;

  // Source oscillator levels after synchronisation.
  typedef struct packed {
    logic primary;
    logic secondary;
    logic internal;
  } scs_osc_s;

endpackage

// ==== scs_sync.sv ====
// Two-stage synchroniser for a group of level inputs.
`timescale 1ns/100ps
module scs_sync
  import scs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ==== scs_edge_count.sv ====
// Counts rising edges of one synchronised source clock level.
`timescale 1ns/100ps
module scs_edge_count
  import scs_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic level,
  output logic [WIDTH-1:0] count
);

  logic level_d;

  // Remembers the previous level to detect a rising edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      level_d <= 1'b0;
    end else if (ce) begin
      level_d <= level;
    end
  end

  // Saturating count of rising edges since the last clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (clear) begin
        count <= '0;
      end else if (level && !level_d && count != '1) begin
        count <= count + WIDTH'(1);
      end
    end
  end

endmodule

// ==== scs_clock_select_monitor.sv ====
// Port checker for the clock select block.
`timescale 1ns/100ps
module scs_clock_select_monitor
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [1:0] active_source,
  input wire logic clock_gate,
  input wire logic cpu_clock_enable,
  input wire logic periph_clock_enable,
  input wire logic switching
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  // All assertions share one clock; all but reset_clear_a stop during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_clear_a: assert property (disable iff (1'b0)
    rst |=> active_source == 2'h0 && !clock_gate && rdata == 8'h00)
    else $error("outputs not cleared after reset");
  rdata_quiet_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  unused_bits_a: assert property (
    $past(rd) && $past(addr) == OSC_CONTROL_ADDR |->
    rdata[6:4] == 3'h0 && !rdata[2]) else $error("unused bits set");
  status_code_a: assert property (
    $past(rd) && $past(addr) == OSC_CONTROL_ADDR && rdata[3] |->
    rdata[1:0] == SEL_DEFAULT) else $error("status with nonzero select");
  timer_run_a: assert property (
    $past(rd) && $past(addr) == TIMER_CONTROL_ADDR && rdata[6] |->
    active_source == 2'h2 || $past(active_source) == 2'h2)
    else $error("timer running without secondary source");
  switch_pause_a: assert property (
    switching |-> !clock_gate && !cpu_clock_enable && !periph_clock_enable)
    else $error("clock enabled during switch");
  pause_min_a: assert property ($rose(switching) |-> switching[*6])
    else $error("switch pause too short");
  pause_bound_a: assert property (
    $rose(switching) |-> ##[1:300] !switching)
    else $error("switch never completes");
  source_hold_a: assert property (
    !switching && !$past(switching) |-> $stable(active_source))
    else $error("source changed without switch");
  sleep_stop_a: assert property (
    wr && addr == SLEEP_CMD_ADDR |-> ##[1:3] !cpu_clock_enable)
    else $error("cpu clock kept after sleep command");
endmodule

bind scs_clock_select scs_clock_select_monitor scs_clock_select_monitor_i (
  .clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
  .active_source(active_source), .clock_gate(clock_gate),
  .cpu_clock_enable(cpu_clock_enable),
  .periph_clock_enable(periph_clock_enable), .switching(switching));

// ==== tb_scs_clock_select.sv ====
// Self-checking testbench for the clock select block.
`timescale 1ns/100ps
module tb_scs_clock_select
  import scs_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, rv;
  logic config_loaded = 1'b0, default_source_config_bit = 1'b1;
  logic two_speed_enable = 1'b0, internal_stable = 1'b1;
  logic primary_osc = 1'b0, secondary_osc = 1'b0, internal_osc = 1'b0;
  logic [1:0] active_source;
  logic clock_gate, cpu_clock_enable, periph_clock_enable, switching;
  logic [3:0] cnt = 4'h0;
  int n_errors = 0, total_checks = 0;

  scs_clock_select scs_clock_select_i (.clk(clk), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .config_loaded(config_loaded),
    .default_source_config_bit(default_source_config_bit),
    .two_speed_enable(two_speed_enable), .primary_osc(primary_osc),
    .secondary_osc(secondary_osc), .internal_osc(internal_osc),
    .internal_stable(internal_stable), .active_source(active_source),
    .clock_gate(clock_gate), .cpu_clock_enable(cpu_clock_enable),
    .periph_clock_enable(periph_clock_enable), .switching(switching));

  // ----------------------------------------------------------------------
  // Clock and source oscillators
  // ----------------------------------------------------------------------
  // The system clock toggles every half period.
  always #2.5 clk = ~clk;
  // Source levels are slower square waves of different rates.
  always @(posedge clk) begin
    cnt <= cnt + 4'h1;
    primary_osc <= cnt[0];
    internal_osc <= cnt[1];
    secondary_osc <= cnt[2];
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_src(input logic [1:0] e);
    #1 chk("active_source", {6'h00, e}, {6'h00, active_source});
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    bus_rd(a);
    chk("register", e, rv);
  endtask
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge clk);
    while (switching !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) chk("switch done", 8'h00, 8'h01);
  endtask
  task automatic do_reset(input logic ts, input logic df, input logic cf);
    @(posedge clk);
    rst <= 1'b1;
    two_speed_enable <= ts;
    default_source_config_bit <= df;
    config_loaded <= cf;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_up();
    do_reset(1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    chk_src(2'h0);
    rd_chk(OSC_CONTROL_ADDR, 8'h00);
    two_speed_enable <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(OSC_CONTROL_ADDR, 8'h08);
    config_loaded <= 1'b1;
    settle();
    chk_src(2'h1);
    rd_chk(OSC_CONTROL_ADDR, 8'h08);
    $display("power-up test done");
  endtask
  task automatic t_select();
    bus_wr(OSC_CONTROL_ADDR, 8'h03);
    chk_src(2'h1);
    repeat (3) @(posedge clk);
    #1 chk("switching", 8'h01, {7'h00, switching});
    chk("clock gate", 8'h00, {7'h00, clock_gate});
    settle();
    chk_src(2'h0);
    rd_chk(OSC_CONTROL_ADDR, 8'h03);
    bus_wr(OSC_CONTROL_ADDR, 8'h02);
    settle();
    chk_src(2'h1);
    rd_chk(OSC_CONTROL_ADDR, 8'h02);
    $display("select test done");
  endtask
  task automatic t_secondary();
    bus_wr(OSC_CONTROL_ADDR, 8'h01);
    settle();
    chk_src(2'h1);
    rd_chk(OSC_CONTROL_ADDR, 8'h02);
    bus_wr(TIMER_CONTROL_ADDR, 8'h08);
    bus_wr(OSC_CONTROL_ADDR, 8'h01);
    settle();
    chk_src(2'h2);
    rd_chk(TIMER_CONTROL_ADDR, 8'h48);
    rd_chk(OSC_CONTROL_ADDR, 8'h01);
    bus_wr(OSC_CONTROL_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    rd_chk(OSC_CONTROL_ADDR, 8'h00);
    rd_chk(TIMER_CONTROL_ADDR, 8'h08);
    settle();
    rd_chk(TIMER_CONTROL_ADDR, 8'h08);
    rd_chk(OSC_CONTROL_ADDR, 8'h08);
    $display("secondary test done");
  endtask
  task automatic t_sleep();
    bus_wr(TIMER_CONTROL_ADDR, 8'h08);
    bus_wr(OSC_CONTROL_ADDR, 8'h80);
    bus_wr(SLEEP_CMD_ADDR, 8'h00);
    rd_chk(POWER_STATE_ADDR, 8'h01);
    chk("cpu enable", 8'h00, {7'h00, cpu_clock_enable});
    chk("periph enable", 8'h01, {7'h00, periph_clock_enable});
    chk("clock gate", 8'h01, {7'h00, clock_gate});
    bus_wr(POWER_STATE_ADDR, 8'h00);
    settle();
    rd_chk(POWER_STATE_ADDR, 8'h00);
    bus_wr(OSC_CONTROL_ADDR, 8'h00);
    bus_wr(SLEEP_CMD_ADDR, 8'h00);
    rd_chk(POWER_STATE_ADDR, 8'h02);
    chk("periph enable", 8'h00, {7'h00, periph_clock_enable});
    chk("clock gate", 8'h00, {7'h00, clock_gate});
    bus_wr(POWER_STATE_ADDR, 8'h00);
    settle();
    $display("sleep test done");
  endtask
  task automatic t_internal_default();
    do_reset(1'b0, 1'b0, 1'b1);
    settle();
    chk_src(2'h0);
    rd_chk(OSC_CONTROL_ADDR, 8'h08);
    rd_chk(4'hf, 8'h00);
    $display("internal default test done");
  endtask

  // The main sequence runs every scenario and ends the run.
  initial begin
    t_power_up();
    t_select();
    t_secondary();
    t_sleep();
    t_internal_default();
    tally_and_finish();
  end
  // The watchdog cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
